// >>> common/lic_pkg.sv
// Purpose: constants for the line interface control/status bank
// Assumes: 25 MHz aclk, AXI4-Lite, word-per-register map
// Notes: register indices are scaled by four for byte addresses
package lic_pkg;
   // ==========================================================
   // Register indices
   localparam logic [7:0] IDX_INFO = 8'h11;
   localparam logic [7:0] IDX_STAT = 8'h16;
   localparam logic [7:0] IDX_MASK = 8'h17;
   localparam logic [7:0] IDX_MODE = 8'h79;
   localparam logic [7:0] IDX_TERM = 8'h7B;
   localparam logic [7:0] IDX_CFG = 8'h7C;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_INFO = 8'h00;
   localparam logic [7:0] RST_STAT = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_TERM = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   // ==========================================================
   // Field positions
   localparam int TERM_RX_LO = 0;
   localparam int TERM_TX_LO = 2;
   localparam int TERM_PS_LO = 4;
   localparam int TERM_INV = 6;
   localparam int TERM_EN = 7;
   localparam int MODE_JSRC = 3;
   localparam int MODE_E1 = 7;
   localparam int CFG_SHORT = 0;
   // Status and mask bit positions
   localparam int ST_TCLK = 0;
   localparam int ST_OPEN = 1;
   localparam int ST_ILIM = 2;
   localparam int ST_CARR = 3;
   localparam int ST_JIT = 4;
   localparam int ST_SIG = 5;
   localparam int ST_TMR = 6;
   localparam int ST_LOW = 7;
   // Synchroniser lanes
   localparam int P_LVL = 0;
   localparam int P_OPEN = 4;
   localparam int P_ILIM = 5;
   localparam int P_CODE = 6;
   localparam int P_CARR = 7;
   localparam int P_JIT = 8;
   localparam int P_SIG = 9;
   localparam int P_LOW = 10;
   localparam int P_TCLK = 11;
   localparam int P_BSTB = 12;
   localparam int P_BERR = 13;
   localparam int P_RXP = 14;
   localparam int P_RXN = 15;
   localparam int NPIN = 16;
   // ==========================================================
   // Timing
   localparam int CLK_NS = 40;
   localparam int TMR_LONG_US = 1000000;
   localparam int TMR_T1_US = 42000;
   localparam int TMR_E1_US = 62500;
   localparam int LOW_US = 50000;
   localparam int CHAN_T1_NS = 5181;
   localparam int CHAN_E1_NS = 3906;
   localparam int TMR_LONG_CYC = TMR_LONG_US / CLK_NS * 1000;
   localparam int TMR_T1_CYC = TMR_T1_US * 1000 / CLK_NS;
   localparam int TMR_E1_CYC = TMR_E1_US * 1000 / CLK_NS;
   localparam int LOW_CYC = LOW_US * 1000 / CLK_NS;
   localparam int CHAN_T1_CYC = CHAN_T1_NS / CLK_NS;
   localparam int CHAN_E1_CYC = CHAN_E1_NS / CLK_NS;
   // Pattern synchroniser figures
   localparam int BS_RUN = 32;
   localparam int BS_WIN = 64;
   localparam int BS_ERR = 6;
   // AXI responses
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage : lic_pkg

// >>> hw/line_interface_ctrl_status.sv
// Purpose: control and status bank of a T1/E1 line interface
// Assumes: analog flags arrive asynchronously on pins
// Notes: all state in one packed struct
// Overview of operation
// RL1: Rx termination code drives termination select
// RL2: Tx termination code in bits 2-3
// RL3: T1 prescale codes, base set by clock source
// RL4: E1 prescale codes on 2.048 MHz base
// RL5: Invert bit inverts coded line signal
// RL6: Enable bit turns on inverted-mark coding
// RL7: Receive level code reported in real time
// RL8: Open-circuit flag reported in real time
// RL9: Current-limit flag reported, limiter on or off
// RL10: Bit-code detector state reported in real time
// RL11: Pattern sync after 32, lost 6/64
// RL12: Tx clock loss after one channel time
// RL13: Open and current-limit conditions, bits 1-2
// RL14: Carrier loss condition in bit 3
// RL15: Jitter trip event, cleared by status read
// RL16: Signalling change event sets bit 5
// RL17: Timer event at error-count interval
// RL18: Low level after about 50 ms
// RL19: Condition masks enable both edges
// RL20: Event masks enable the interrupt
// RL21: Clock source select steers jitter clock
// RL22: Mode bit selects T1 or E1
// RL23: Interrupt while any enabled bit pending
// RL24: Read clears; next edge raises again
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module line_interface_ctrl_status #(
   parameter int AW = 12,
   parameter int TMR_LONG = lic_pkg::TMR_LONG_CYC,
   parameter int TMR_T1 = lic_pkg::TMR_T1_CYC,
   parameter int TMR_E1 = lic_pkg::TMR_E1_CYC,
   parameter int LOW_HOLD = lic_pkg::LOW_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] rx_level_in,
   input wire logic tx_open_circuit,
   input wire logic tx_current_limit_hit,
   input wire logic bit_oriented_code,
   input wire logic rx_carrier_lost,
   input wire logic jitter_near_limit,
   input wire logic rx_sig_change,
   input wire logic level_below_thr,
   input wire logic li_tx_clock_in,
   input wire logic bert_bit_strobe,
   input wire logic bert_bit_error,
   input wire logic rx_line_pos,
   input wire logic rx_line_neg,
   input wire logic tx_pos_in,
   input wire logic tx_neg_in,
   output logic tx_line_pos,
   output logic tx_line_neg,
   output logic rx_pos_out,
   output logic rx_neg_out,
   output logic [1:0] rx_term_sel,
   output logic [1:0] tx_term_sel,
   output logic [1:0] mclk_prescale,
   output logic mclk_base_2048,
   output logic jitter_clk_source_sel,
   output logic line_mode_e1_sel,
   output logic line_code_enable,
   output logic irq
);
   localparam int NP = lic_pkg::NPIN;
   localparam int TW = $clog2(TMR_LONG + 1);
   localparam int LW = $clog2(LOW_HOLD + 1);

   typedef enum {SEL_NONE, SEL_INFO, SEL_STAT, SEL_MASK,
                 SEL_MODE, SEL_TERM, SEL_CFG} sel_t;

   typedef struct packed {
      logic [NP-1:0] s1;
      logic [NP-1:0] s2;
      logic [NP-1:0] s3;
      logic [7:0] term;
      logic [7:0] mode;
      logic [7:0] cfg;
      logic [7:0] mask;
      logic [7:0] stat;
      logic [4:0] cprev;
      logic [TW-1:0] tmr;
      logic [LW-1:0] lcnt;
      logic low;
      logic [7:0] tcnt;
      logic tlost;
      logic [5:0] run;
      logic [5:0] win;
      logic [2:0] errs;
      logic lock;
      logic [AW-1:0] waddr;
      logic aw_have;
      logic [7:0] wdat;
      logic wlane0;
      logic w_have;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic txp;
      logic txn;
      logic rxp;
      logic rxn;
      logic base;
      logic irq;
   } st_t;

   st_t s_r;
   st_t s_nxt;
   logic [NP-1:0] pins;

   // Decode shared by the read and write paths
   function automatic sel_t reg_sel(input logic [AW-1:0] a);
      sel_t r;
      r = SEL_NONE;
      if (a[1:0] == 2'h0 && a[AW-1:10] == '0) begin
         unique case (a[9:2])
            lic_pkg::IDX_INFO: r = SEL_INFO;
            lic_pkg::IDX_STAT: r = SEL_STAT;
            lic_pkg::IDX_MASK: r = SEL_MASK;
            lic_pkg::IDX_MODE: r = SEL_MODE;
            lic_pkg::IDX_TERM: r = SEL_TERM;
            lic_pkg::IDX_CFG: r = SEL_CFG;
            default: r = SEL_NONE;
         endcase
      end
      return r;
   endfunction : reg_sel

   assign pins = {rx_line_neg, rx_line_pos, bert_bit_error,
                  bert_bit_strobe, li_tx_clock_in,
                  level_below_thr, rx_sig_change,
                  jitter_near_limit, rx_carrier_lost,
                  bit_oriented_code, tx_current_limit_hit,
                  tx_open_circuit, rx_level_in};

   always_comb begin
      logic e1;
      logic [7:0] info;
      logic [7:0] set;
      logic [7:0] clr;
      logic [4:0] cnow;
      logic tick;
      logic [TW-1:0] tlim;
      logic [7:0] clim;
      logic bstb;
      logic berr;
      logic inv;
      sel_t rs;
      sel_t ws;
      e1 = 1'b0;
      info = 8'h00;
      set = 8'h00;
      clr = 8'h00;
      cnow = 5'h00;
      tick = 1'b0;
      tlim = '0;
      clim = 8'h00;
      bstb = 1'b0;
      berr = 1'b0;
      inv = 1'b0;
      rs = SEL_NONE;
      ws = SEL_NONE;
      s_nxt = s_r;

      // ========================================================
      // Pin synchronisers
      s_nxt.s1 = pins;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      e1 = s_r.mode[lic_pkg::MODE_E1]; // [RL22]

      // ========================================================
      // Real-time information
      info = {s_r.lock, s_r.s2[lic_pkg::P_CODE],
              s_r.s2[lic_pkg::P_ILIM],
              s_r.s2[lic_pkg::P_OPEN],
              s_r.s2[lic_pkg::P_LVL +: 4]}; // [RL7] [RL8] [RL9] [RL10]

      // ========================================================
      // Pattern synchroniser
      bstb = s_r.s2[lic_pkg::P_BSTB] & ~s_r.s3[lic_pkg::P_BSTB];
      berr = s_r.s2[lic_pkg::P_BERR];
      if (bstb) begin
         if (!s_r.lock) begin
            if (berr) begin
               s_nxt.run = 6'h00;
            end else if (32'(s_r.run) == lic_pkg::BS_RUN - 1) begin
               s_nxt.lock = 1'b1; // [RL11]
               s_nxt.run = 6'h00;
               s_nxt.win = 6'h00;
               s_nxt.errs = 3'h0;
            end else begin
               s_nxt.run = s_r.run + 6'h01;
            end
         end else begin
            // Fixed 64-bit windows; a cheap stand-in for a sliding one
            if (berr && 32'(s_r.errs) == lic_pkg::BS_ERR - 1) begin
               s_nxt.lock = 1'b0; // [RL11]
               s_nxt.run = 6'h00;
            end else if (32'(s_r.win) == lic_pkg::BS_WIN - 1) begin
               s_nxt.win = 6'h00;
               s_nxt.errs = 3'h0;
            end else begin
               s_nxt.win = s_r.win + 6'h01;
               s_nxt.errs = s_r.errs + {2'h0, berr};
            end
         end
      end

      // ========================================================
      // Transmit clock watchdog
      clim = e1 ? 8'(lic_pkg::CHAN_E1_CYC) : 8'(lic_pkg::CHAN_T1_CYC);
      if (s_r.s2[lic_pkg::P_TCLK] != s_r.s3[lic_pkg::P_TCLK]) begin
         s_nxt.tcnt = 8'h00;
         s_nxt.tlost = 1'b0;
      end else if (s_r.tcnt >= clim) begin
         s_nxt.tlost = 1'b1; // [RL12]
      end else begin
         s_nxt.tcnt = s_r.tcnt + 8'h01;
      end

      // ========================================================
      // Input level filter
      if (!s_r.s2[lic_pkg::P_LOW]) begin
         s_nxt.lcnt = '0;
         s_nxt.low = 1'b0;
      end else if (32'(s_r.lcnt) >= LOW_HOLD - 1) begin
         s_nxt.low = 1'b1; // [RL18]
      end else begin
         s_nxt.lcnt = s_r.lcnt + LW'(1);
      end

      // ========================================================
      // Error-count interval timer
      if (!s_r.cfg[lic_pkg::CFG_SHORT]) begin
         tlim = TW'(TMR_LONG - 1);
      end else begin
         tlim = e1 ? TW'(TMR_E1 - 1) : TW'(TMR_T1 - 1); // [RL17]
      end
      if (s_r.tmr >= tlim) begin
         s_nxt.tmr = '0;
         tick = 1'b1; // [RL17]
      end else begin
         s_nxt.tmr = s_r.tmr + TW'(1);
      end

      // ========================================================
      // Latched status
      cnow = {s_r.low, s_r.s2[lic_pkg::P_CARR],
              s_r.s2[lic_pkg::P_ILIM],
              s_r.s2[lic_pkg::P_OPEN], s_r.tlost};
      s_nxt.cprev = cnow;
      // Conditions latch on either edge
      set[3:0] = cnow[3:0] ^ s_r.cprev[3:0]; // [RL12] [RL13] [RL14] [RL24]
      set[lic_pkg::ST_LOW] = cnow[4] ^ s_r.cprev[4]; // [RL18]
      set[lic_pkg::ST_JIT] = s_r.s2[lic_pkg::P_JIT]
                             & ~s_r.s3[lic_pkg::P_JIT]; // [RL15]
      set[lic_pkg::ST_SIG] = s_r.s2[lic_pkg::P_SIG]
                             & ~s_r.s3[lic_pkg::P_SIG]; // [RL16]
      set[lic_pkg::ST_TMR] = tick; // [RL17]

      // ========================================================
      // AXI4-Lite read
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_r.arready && s_axi_arvalid) begin
         rs = reg_sel(s_axi_araddr);
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = lic_pkg::RESP_OK;
         unique case (rs)
            SEL_INFO: s_nxt.rdata = info;
            SEL_STAT: begin
               s_nxt.rdata = s_r.stat;
               clr = s_r.stat; // [RL15] [RL24]
            end
            SEL_MASK: s_nxt.rdata = s_r.mask;
            SEL_MODE: s_nxt.rdata = s_r.mode;
            SEL_TERM: s_nxt.rdata = s_r.term;
            SEL_CFG: s_nxt.rdata = s_r.cfg;
            SEL_NONE: begin
               s_nxt.rdata = 8'h00;
               s_nxt.rresp = lic_pkg::RESP_ERR;
            end
         endcase
      end
      // New edge in the read cycle survives the clear
      s_nxt.stat = (s_r.stat & ~clr) | set; // [RL24]

      // ========================================================
      // AXI4-Lite write
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.awready && s_axi_awvalid) begin
         s_nxt.waddr = s_axi_awaddr;
         s_nxt.aw_have = 1'b1;
      end
      if (s_r.wready && s_axi_wvalid) begin
         s_nxt.wdat = s_axi_wdata[7:0];
         s_nxt.wlane0 = s_axi_wstrb[0];
         s_nxt.w_have = 1'b1;
      end
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         ws = reg_sel(s_r.waddr);
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = lic_pkg::RESP_OK;
         unique case (ws)
            SEL_MASK: begin
               if (s_r.wlane0) begin
                  s_nxt.mask = s_r.wdat; // [RL19] [RL20]
               end
            end
            SEL_MODE: begin
               if (s_r.wlane0) begin
                  s_nxt.mode = s_r.wdat; // [RL21] [RL22]
               end
            end
            SEL_TERM: begin
               if (s_r.wlane0) begin
                  s_nxt.term = s_r.wdat; // [RL1] [RL2]
               end
            end
            SEL_CFG: begin
               if (s_r.wlane0) begin
                  s_nxt.cfg = s_r.wdat;
               end
            end
            SEL_INFO, SEL_STAT: begin
               // Read-only; status clears only by reading
            end
            SEL_NONE: s_nxt.bresp = lic_pkg::RESP_ERR;
         endcase
      end
      // One address and one data beat held at a time
      s_nxt.awready = ~s_nxt.aw_have;
      s_nxt.wready = ~s_nxt.w_have;
      s_nxt.arready = ~s_nxt.rvalid;
      s_nxt.base = s_nxt.mode[lic_pkg::MODE_E1] | s_nxt.mode[lic_pkg::MODE_JSRC]; // [RL3] [RL4]

      // ========================================================
      // Coded line path
      inv = s_r.term[lic_pkg::TERM_EN] & s_r.term[lic_pkg::TERM_INV]; // [RL5] [RL6]
      s_nxt.txp = tx_pos_in ^ inv; // [RL5]
      s_nxt.txn = tx_neg_in ^ inv;
      s_nxt.rxp = s_r.s2[lic_pkg::P_RXP] ^ inv; // [RL5]
      s_nxt.rxn = s_r.s2[lic_pkg::P_RXN] ^ inv;

      // ========================================================
      // Interrupt
      s_nxt.irq = |(s_nxt.stat & s_r.mask); // [RL19] [RL20] [RL23]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.term <= lic_pkg::RST_TERM;
         s_r.mode <= lic_pkg::RST_MODE;
         s_r.cfg <= lic_pkg::RST_CFG;
         s_r.mask <= lic_pkg::RST_MASK;
         s_r.stat <= lic_pkg::RST_STAT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = {24'h000000, s_r.rdata};
   assign s_axi_rresp = s_r.rresp;
   assign tx_line_pos = s_r.txp;
   assign tx_line_neg = s_r.txn;
   assign rx_pos_out = s_r.rxp;
   assign rx_neg_out = s_r.rxn;
   assign rx_term_sel = s_r.term[lic_pkg::TERM_RX_LO +: 2]; // [RL1]
   assign tx_term_sel = s_r.term[lic_pkg::TERM_TX_LO +: 2]; // [RL2]
   assign mclk_prescale = s_r.term[lic_pkg::TERM_PS_LO +: 2]; // [RL3] [RL4]
   // E1 always runs on the 2.048 MHz family
   assign mclk_base_2048 = s_r.base; // [RL3] [RL4]
   assign jitter_clk_source_sel = s_r.mode[lic_pkg::MODE_JSRC]; // [RL21]
   assign line_mode_e1_sel = s_r.mode[lic_pkg::MODE_E1]; // [RL22]
   assign line_code_enable = s_r.term[lic_pkg::TERM_EN]; // [RL6]
   assign irq = s_r.irq;
endmodule : line_interface_ctrl_status

// >>> bench/line_interface_ctrl_status_sva.sv
// Purpose: port checks for the line interface bank
// Assumes: one clock, sync active-low reset
// Notes: control outputs may move only at a write commit
`timescale 1ns/1ps
module line_interface_ctrl_status_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] rx_term_sel,
   input wire logic [1:0] tx_term_sel,
   input wire logic [1:0] mclk_prescale,
   input wire logic mclk_base_2048,
   input wire logic jitter_clk_source_sel,
   input wire logic line_mode_e1_sel,
   input wire logic line_code_enable,
   input wire logic tx_pos_in,
   input wire logic tx_line_pos,
   input wire logic rx_line_pos,
   input wire logic rx_pos_out,
   input wire logic irq
);
   // ==========================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_term_hold:
   assert property (!$rose(s_axi_bvalid) |-> $stable({rx_term_sel, tx_term_sel}))
      else $error("termination select moved without a write");
   chk_mode_hold:
   assert property (!$rose(s_axi_bvalid) |-> $stable({mclk_prescale, jitter_clk_source_sel,
      line_mode_e1_sel, line_code_enable})) else $error("mode moved without a write");
   chk_e1_base:
   assert property (line_mode_e1_sel |-> mclk_base_2048) else $error("E1 base wrong");
   chk_pll_base:
   assert property (jitter_clk_source_sel |-> mclk_base_2048) else $error("PLL base wrong");
   chk_t1_base:
   assert property (!line_mode_e1_sel && !jitter_clk_source_sel |-> !mclk_base_2048)
      else $error("T1 base wrong");
   chk_tx_plain:
   assert property ($past(aresetn) && !$past(line_code_enable) |-> tx_line_pos == $past(tx_pos_in))
      else $error("tx data altered while coding off");
   chk_rx_plain:
   assert property ($past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn) &&
      !$past(line_code_enable) |-> rx_pos_out == $past(rx_line_pos, 3))
      else $error("rx data altered while coding off");
   chk_read_width:
   assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_irq_reset:
   assert property ($rose(aresetn) |-> !irq) else $error("irq high after reset");
   cover property ($rose(s_axi_bvalid));
   cover property ($rose(irq));
   cover property (line_code_enable && tx_pos_in);
endmodule : line_interface_ctrl_status_sva
bind line_interface_ctrl_status line_interface_ctrl_status_sva
   i_line_interface_ctrl_status_sva (.*);

// >>> bench/line_model.sv
// Purpose: line side model, tx clock and pattern bits
// Assumes: tx clock stands still while run is low
// Notes: error line held low between strobes
`timescale 1ns/1ps
module line_model (
   input wire logic aclk,
   input wire logic run,
   input wire logic err,
   output logic li_tx_clock_in,
   output logic bert_bit_strobe,
   output logic bert_bit_error
);
   logic [1:0] ph_r;
   initial begin
      ph_r = 2'h0;
      li_tx_clock_in = 1'b0;
   end
   always @(posedge aclk) begin
      ph_r <= ph_r + 2'h1;
      if (run && ph_r == 2'h0) li_tx_clock_in <= !li_tx_clock_in;
   end
   assign bert_bit_strobe = ph_r[1];
   assign bert_bit_error = err & ph_r[1];
endmodule : line_model

// >>> bench/tb_line_interface_ctrl_status.sv
// Purpose: self-checking bench for the line interface bank
// Assumes: small timer parameters
// Notes: timer bit is masked out of the multi-bit status compares in t_status
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb_line_interface_ctrl_status;
   localparam int AW = 12;
   localparam int TL = 40;
   localparam int TT1 = 20;
   localparam int ILH = 10;
   localparam logic [11:0] A_INFO = {2'h0, lic_pkg::IDX_INFO, 2'h0};
   localparam logic [11:0] A_STAT = {2'h0, lic_pkg::IDX_STAT, 2'h0};
   localparam logic [11:0] A_MASK = {2'h0, lic_pkg::IDX_MASK, 2'h0};
   localparam logic [11:0] A_MODE = {2'h0, lic_pkg::IDX_MODE, 2'h0};
   localparam logic [11:0] A_TERM = {2'h0, lic_pkg::IDX_TERM, 2'h0};
   localparam logic [11:0] A_CFG = {2'h0, lic_pkg::IDX_CFG, 2'h0};
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b1, err = 1'b1;
   logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, rx_level_in = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_term_sel, tx_term_sel, mclk_prescale;
   logic tx_open_circuit = 1'b0, tx_current_limit_hit = 1'b0, bit_oriented_code = 1'b0;
   logic rx_carrier_lost = 1'b0, jitter_near_limit = 1'b0, rx_sig_change = 1'b0;
   logic level_below_thr = 1'b0, rx_line_pos = 1'b0, rx_line_neg = 1'b0;
   logic tx_pos_in = 1'b0, tx_neg_in = 1'b0;
   logic li_tx_clock_in, bert_bit_strobe, bert_bit_error;
   logic tx_line_pos, tx_line_neg, rx_pos_out, rx_neg_out, mclk_base_2048;
   logic jitter_clk_source_sel, line_mode_e1_sel, line_code_enable, irq;
   logic [7:0] d;
   logic [1:0] r;
   int bad_count = 0, n_checks = 0, cyc_n = 0;
   line_interface_ctrl_status #(.AW(AW), .TMR_LONG(TL), .TMR_T1(TT1), .TMR_E1(25),
      .LOW_HOLD(ILH)) i_line_interface_ctrl_status (.*);
   line_model i_line_model (.*);
   initial forever #20 aclk = ~aclk;
   // ==========================================
   // Bus tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : cyc
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awready && !ad) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !wd) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // ==========================================
   // Scenarios
   task automatic t_regs();
      rd(A_STAT); `CK(d, lic_pkg::RST_STAT)
      rd(A_INFO); `CK(d[6:0], 7'h00)
      rd(A_MASK); `CK(d, lic_pkg::RST_MASK)
      rd(A_TERM); `CK(d, lic_pkg::RST_TERM)
      rd(12'h3FC); `CK({r, d}, {lic_pkg::RESP_ERR, 8'h00})
      wr(12'h045, 8'hFF); `CK(r, lic_pkg::RESP_ERR)
      wr(A_INFO, 8'h0F); `CK(r, lic_pkg::RESP_OK)
      rd(A_INFO); `CK(d[3:0], 4'h0)
      wr(A_MASK, 8'hA5); rd(A_MASK); `CK(d, 8'hA5)
      wr(A_MASK, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_term();
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         wr(A_TERM, {2'h0, c, ~c, c});
         cyc(1);
         `CK(rx_term_sel, c)
         `CK(tx_term_sel, ~c)
         `CK(mclk_prescale, c)
      end
      wr(A_TERM, 8'h00);
      $display("t_term done");
   endtask : t_term
   task automatic t_mode();
      logic [7:0] v;
      for (int j = 0; j < 4; j++) begin
         v = {j[1], 3'h0, j[0], 3'h0};
         wr(A_MODE, v);
         cyc(1);
         `CK(mclk_base_2048, v[7] | v[3])
         `CK(jitter_clk_source_sel, v[3])
         `CK(line_mode_e1_sel, v[7])
      end
      wr(A_MODE, 8'h00);
      $display("t_mode done");
   endtask : t_mode
   task automatic t_cmi();
      wr(A_TERM, 8'hC0);
      tx_pos_in <= 1'b1;
      rx_line_pos <= 1'b1;
      cyc(6);
      `CK({tx_line_pos, tx_line_neg, rx_pos_out, rx_neg_out}, 4'h5)
      wr(A_TERM, 8'h40);
      cyc(3);
      `CK({tx_line_pos, rx_pos_out, line_code_enable}, 3'h6)
      wr(A_TERM, 8'h80);
      cyc(3);
      `CK({tx_line_pos, rx_pos_out, line_code_enable}, 3'h7)
      wr(A_TERM, 8'h00);
      $display("t_cmi done");
   endtask : t_cmi
   task automatic t_info();
      for (int i = 0; i < 16; i++) begin
         rx_level_in <= 4'(i);
         tx_open_circuit <= i[0];
         tx_current_limit_hit <= i[1];
         bit_oriented_code <= i[2];
         cyc(5);
         rd(A_INFO); `CK(d[6:0], {i[2], i[1], i[0], 4'(i)})
      end
      {rx_level_in, tx_open_circuit, tx_current_limit_hit, bit_oriented_code} <= '0;
      $display("t_info done");
   endtask : t_info
   task automatic t_pattern_sync_now();
      err <= 1'b1;
      cyc(600);
      rd(A_INFO); `CK(d[7], 1'b0)
      err <= 1'b0;
      cyc(90);
      rd(A_INFO); `CK(d[7], 1'b0)
      cyc(60);
      rd(A_INFO); `CK(d[7], 1'b1)
      err <= 1'b1;
      cyc(60);
      rd(A_INFO); `CK(d[7], 1'b0)
      $display("t_pattern_sync_now done");
   endtask : t_pattern_sync_now
   task automatic t_status();
      wr(A_MASK, 8'h02); rd(A_STAT);
      tx_open_circuit <= 1'b1;
      cyc(6); `CK(irq, 1'b1)
      rd(A_STAT); `CK(d & 8'hBF, 8'h02)
      cyc(1); `CK(irq, 1'b0)
      tx_open_circuit <= 1'b0;
      cyc(6); `CK(irq, 1'b1)
      rd(A_STAT); `CK(d & 8'hBF, 8'h02)
      tx_current_limit_hit <= 1'b1;
      rx_carrier_lost <= 1'b1;
      cyc(6); `CK(irq, 1'b0)
      rd(A_STAT); `CK(d & 8'hBF, 8'h0C)
      wr(A_MASK, 8'h30);
      jitter_near_limit <= 1'b1;
      cyc(2); jitter_near_limit <= 1'b0;
      cyc(6); `CK(irq, 1'b1)
      rd(A_STAT); `CK(d & 8'hBF, 8'h10)
      rd(A_STAT); `CK(d & 8'hBF, 8'h00)
      rx_sig_change <= 1'b1;
      cyc(2); rx_sig_change <= 1'b0;
      cyc(6); rd(A_STAT); `CK(d & 8'hBF, 8'h20)
      level_below_thr <= 1'b1;
      cyc(4); level_below_thr <= 1'b0;
      cyc(6); rd(A_STAT); `CK(d & 8'hBF, 8'h00)
      level_below_thr <= 1'b1;
      cyc(ILH + 8); rd(A_STAT); `CK(d & 8'hBF, 8'h80)
      {level_below_thr, tx_current_limit_hit, rx_carrier_lost} <= '0;
      cyc(ILH + 8); rd(A_STAT);
      run <= 1'b0;
      cyc(100); rd(A_STAT); `CK(d[0], 1'b0)
      cyc(60); rd(A_STAT); `CK(d[0], 1'b1)
      run <= 1'b1;
      wr(A_MASK, 8'h00); rd(A_STAT);
      cyc(TL + 4); rd(A_STAT); `CK(d[6], 1'b1)
      wr(A_CFG, 8'h01); wr(A_MASK, 8'h40); rd(A_STAT);
      cyc(TT1 + 4); `CK(irq, 1'b1)
      wr(A_MASK, 8'h00);
      $display("t_status done");
   endtask : t_status
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   always @(posedge aclk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_term();
      t_mode();
      t_cmi();
      t_info();
      t_pattern_sync_now();
      t_status();
      print_verdict();
   end
endmodule : tb_line_interface_ctrl_status
